// ### logic/bsq_pkg.sv
/*
  Shared constants, operation codes and state codes of the branch sequencer.
  Assumes a 40 MHz core clock and a 20-bit program counter.
*/
package bsq_pkg;
  localparam int          PC_W          = 20;
  localparam int          FLAG_C_BIT    = 31;
  localparam int          FLAG_Z_BIT    = 30;
  localparam logic [19:0] PC_RESET      = 20'h00000;
  localparam logic [19:0] HUB_EXEC_BASE = 20'h00400;
  localparam logic [19:0] STEP_COG      = 20'h00001;
  localparam logic [19:0] STEP_HUB      = 20'h00004;
  localparam logic [31:0] HUB_LONG      = 32'h00000004;
  localparam logic [31:0] PTR_RESET     = 32'h00000000;
  localparam logic [31:0] ALL_ONES      = 32'hFFFFFFFF;
  localparam logic [31:0] SKIP_RESET    = 32'h00000000;
  localparam logic [8:0]  REG_TOP       = 9'h1FF;
  localparam logic [8:0]  REG_PARAM_A   = 9'h1F6;
  localparam logic [8:0]  REG_PARAM_B   = 9'h1F7;
  localparam logic [8:0]  INT_RES_DST [4] = '{9'h1FE, 9'h1F4, 9'h1F2, 9'h1F0};

  typedef enum logic [5:0] {
    OP_NOP                       = 6'b000000,
    OP_CALL_IMM                  = 6'b000001,
    OP_CALL_REG                  = 6'b000010,
    OP_CALL_HUB_STACK_A_IMM      = 6'b000011,
    OP_CALL_HUB_STACK_A_REG      = 6'b000100,
    OP_CALL_HUB_STACK_B_IMM      = 6'b000101,
    OP_CALL_HUB_STACK_B_REG      = 6'b000110,
    OP_CALL_TO_REGISTER          = 6'b000111,
    OP_CALL_TO_REGISTER_IMM      = 6'b001000,
    OP_CALL_WITH_PARAM_A         = 6'b001001,
    OP_CALL_WITH_PARAM_B         = 6'b001010,
    OP_JUMP_IMM                  = 6'b001011,
    OP_JUMP_REG                  = 6'b001100,
    OP_RELATIVE_JUMP             = 6'b001101,
    OP_EXECUTE_FAST_SKIP         = 6'b001110,
    OP_REPEAT_BLOCK              = 6'b001111,
    OP_RETURN                    = 6'b010000,
    OP_RETURN_HUB_STACK_A        = 6'b010001,
    OP_RETURN_HUB_STACK_B        = 6'b010010,
    OP_SKIP                      = 6'b010011,
    OP_FAST_SKIP                 = 6'b010100,
    OP_INTERRUPT_RETURN          = 6'b010101,
    OP_INTERRUPT_RESUME          = 6'b010110,
    OP_DEC_BR_ZERO               = 6'b011000,
    OP_DECREMENT_BRANCH_NONZERO  = 6'b011001,
    OP_DEC_BR_ONES               = 6'b011010,
    OP_DEC_BR_NOT_ONES           = 6'b011011,
    OP_INC_BR_ZERO               = 6'b011100,
    OP_INCREMENT_BRANCH_NONZERO  = 6'b011101,
    OP_TEST_BR_ZERO              = 6'b100000,
    OP_TEST_BR_NONZERO           = 6'b100001,
    OP_TEST_BR_ONES              = 6'b100010,
    OP_TEST_BR_NOT_ONES          = 6'b100011,
    OP_TEST_BR_SIGN              = 6'b100100,
    OP_TEST_BR_NOT_SIGN          = 6'b100101,
    OP_TEST_BRANCH_OVERFLOW      = 6'b100110
  } bsq_op_e;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_HUB_WR = 2'b01,
    ST_HUB_RD = 2'b10
  } bsq_state_e;
endpackage

// ### logic/bsq_ret_stack.sv
/*
  Circular return stack with registered top-of-stack output.
  Assumes push and pop are never requested together; push then wins.
*/
`timescale 1ns/1ps
module bsq_ret_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] top
);
  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    sp;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[sp] <= din;
  end

  // Top register tracks the newest live entry
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sp  <= '0;
      top <= '0;
    end
    else if (push)
    begin
      sp  <= sp + AW'(1);
      top <= din;
    end
    else if (pop)
    begin
      sp  <= sp - AW'(1);
      top <= mem[sp - AW'(2)];
    end
  end
endmodule // bsq_ret_stack

// ### logic/bsq_branch_sequencer.sv
/*
  Branch and program-flow sequencer of one core: calls, returns, conditional
  branches, repeat loops and skip masks. Assumes the core presents one
  instruction at a time with its operand values already read.
*/
// Overview of operation
// RQ1 - Immediate call pushes {C,Z,zeros,PC} and jumps absolute or relative.
// RQ2 - Register call pushes return word, loads C, Z and PC from operand.
// RQ3 - Hub calls write return word at pointer A or B, then post-increment.
// RQ4 - Call-to-register stores return word in destination, flags from source.
// RQ5 - Immediate call-to-register writes one of four fixed registers, then branches.
// RQ6 - Call-with-parameter pushes, copies destination into a parameter register.
// RQ7 - Decrement, write back, branch on zero, nonzero, all ones, not ones.
// RQ8 - Increment, write back, branch on zero or nonzero.
// RQ9 - Test branches leave register, branch on zero, ones or sign.
// RQ10 - Overflow test branches when bit 31 differs from carry.
// RQ11 - Register jump loads C, Z, PC from operand without pushing.
// RQ12 - Relative jump adds 20 bits locally, 18 bits times four in hub.
// RQ13 - Execute-fast-skip jumps to ten-bit address and loads fast-skip pattern.
// RQ14 - Repeat runs next block count times; zero count forever, zero length none.
// RQ15 - Interrupt return and resume are flag-restoring register calls per level.
// RQ16 - Stack return pops and restores requested flags and PC.
// RQ17 - Hub returns pre-decrement pointer A or B, read the long there, restore state.
// RQ18 - Skip cancels following instructions whose mask bit is one, bit 0 first.
// RQ19 - Fast skip leaps the PC over masked instructions; illegal in hub.
// RQ20 - False condition continues sequentially with writeback and flags unchanged.
`timescale 1ns/1ps
module bsq_branch_sequencer #(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [5:0]  cmd_op,
  input  wire logic [31:0] cmd_d,
  input  wire logic [31:0] cmd_s,
  input  wire logic [8:0]  cmd_dst,
  input  wire logic        cmd_rel,
  input  wire logic        cmd_abs,
  input  wire logic [1:0]  cmd_sel,
  input  wire logic        cmd_write_carry,
  input  wire logic        cmd_write_zero,
  input  wire logic        step_valid,
  output logic             cancel,
  output logic             illegal,
  output logic [19:0]      pc,
  output logic             flag_c,
  output logic             flag_z,
  output logic [31:0]      hub_pointer_a,
  output logic [31:0]      hub_pointer_b,
  output logic             reg_we,
  output logic [8:0]       reg_waddr,
  output logic [31:0]      reg_wdata,
  output logic             hub_req,
  output logic             hub_we,
  output logic [19:0]      hub_addr,
  output logic [31:0]      hub_wdata,
  input  wire logic [31:0] hub_rdata,
  input  wire logic        hub_ack
);
  bsq_pkg::bsq_state_e state;
  bsq_pkg::bsq_op_e    op;
  logic        hubex, op_go, step_go, fast_leap, taken, rep_wrap, rep_end_hit;
  logic [19:0] seq_step, next_seq, tgt, next_pc;
  logic        next_c, next_z;
  logic [31:0] ret_word, stack_top, dec_res, inc_res;
  logic        push, pop, wb_en, hub_go, hub_rd, hub_b, ptr_load_a, ptr_load_b;
  logic        load_skip, skip_fast_in, load_rep, fault;
  logic [8:0]  wb_addr;
  logic [31:0] wb_data, skip_val, skip_mask;
  logic [19:0] next_hub_addr;
  logic        skip_fast, pend_wc, pend_wz, pend_b;
  logic        rep_active, rep_forever;
  logic [31:0] rep_left;
  logic [19:0] rep_start, rep_end;

  function automatic logic pick(input logic wr, input logic bit_in, input logic cur);
    pick = wr ? bit_in : cur;
  endfunction

  function automatic logic br_cond(input bsq_pkg::bsq_op_e o, input logic [31:0] d,
                                   input logic [31:0] dec, input logic [31:0] inc, input logic c);
    br_cond = 1'b0;
    unique case (o)
      bsq_pkg::OP_DEC_BR_ZERO:              br_cond = (dec == '0);
      bsq_pkg::OP_DECREMENT_BRANCH_NONZERO: br_cond = (dec != '0);
      bsq_pkg::OP_DEC_BR_ONES:              br_cond = (dec == bsq_pkg::ALL_ONES);
      bsq_pkg::OP_DEC_BR_NOT_ONES:          br_cond = (dec != bsq_pkg::ALL_ONES);
      bsq_pkg::OP_INC_BR_ZERO:              br_cond = (inc == '0);
      bsq_pkg::OP_INCREMENT_BRANCH_NONZERO: br_cond = (inc != '0);
      bsq_pkg::OP_TEST_BR_ZERO:             br_cond = (d == '0);
      bsq_pkg::OP_TEST_BR_NONZERO:          br_cond = (d != '0);
      bsq_pkg::OP_TEST_BR_ONES:             br_cond = (d == bsq_pkg::ALL_ONES);
      bsq_pkg::OP_TEST_BR_NOT_ONES:         br_cond = (d != bsq_pkg::ALL_ONES);
      bsq_pkg::OP_TEST_BR_SIGN:             br_cond = d[31];
      bsq_pkg::OP_TEST_BR_NOT_SIGN:         br_cond = !d[31];
      bsq_pkg::OP_TEST_BRANCH_OVERFLOW:     br_cond = (d[31] != c);
      default:                              br_cond = 1'b0;
    endcase
  endfunction

  assign op        = bsq_pkg::bsq_op_e'(cmd_op);
  assign hubex     = (pc >= bsq_pkg::HUB_EXEC_BASE);
  assign seq_step  = hubex ? bsq_pkg::STEP_HUB : bsq_pkg::STEP_COG;
  assign next_seq  = pc + seq_step;
  assign tgt       = (cmd_rel && !cmd_abs) ? next_seq + cmd_s[19:0] : cmd_s[19:0];
  assign ret_word  = {flag_c, flag_z, 10'h000, next_seq};
  assign dec_res   = cmd_d - 32'h00000001;
  assign inc_res   = cmd_d + 32'h00000001;
  assign taken     = br_cond(op, cmd_d, dec_res, inc_res, flag_c);
  assign fast_leap = skip_fast && skip_mask[0] && (state == bsq_pkg::ST_RUN);
  assign cancel    = !skip_fast && skip_mask[0]; // RQ18
  assign cmd_ready = (state == bsq_pkg::ST_RUN) && !fast_leap;
  assign op_go     = cmd_valid && cmd_ready && !cancel;
  assign step_go   = cmd_ready && !op_go && (step_valid || cmd_valid);
  assign rep_end_hit = rep_active && (next_seq == rep_end);
  assign rep_wrap  = rep_end_hit && (rep_forever || rep_left != 32'h00000001);

  bsq_ret_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (32)
  ) u_stack (
    .clk  (clk),
    .nrst (nrst),
    .push (push),
    .pop  (pop),
    .din  (ret_word),
    .top  (stack_top)
  );

  // Operation decode
  always_comb
  begin
    next_pc       = (step_go && rep_wrap) ? rep_start : next_seq; // RQ14
    next_c        = flag_c;
    next_z        = flag_z;
    push          = 1'b0;
    pop           = 1'b0;
    wb_en         = 1'b0;
    wb_addr       = cmd_dst;
    wb_data       = ret_word;
    hub_go        = 1'b0;
    hub_rd        = 1'b0;
    hub_b         = 1'b0;
    next_hub_addr = hub_pointer_a[19:0];
    ptr_load_a    = 1'b0;
    ptr_load_b    = 1'b0;
    load_skip     = 1'b0;
    skip_fast_in  = 1'b0;
    skip_val      = cmd_d;
    load_rep      = 1'b0;
    fault         = 1'b0;
    if (op_go)
    begin
      unique case (op)
        bsq_pkg::OP_CALL_IMM:
        begin
          push    = 1'b1; // RQ1
          next_pc = tgt;
        end
        bsq_pkg::OP_CALL_REG, bsq_pkg::OP_JUMP_REG:
        begin
          push    = (op == bsq_pkg::OP_CALL_REG); // RQ2
          next_c  = pick(cmd_write_carry, cmd_d[bsq_pkg::FLAG_C_BIT], flag_c); // RQ11
          next_z  = pick(cmd_write_zero, cmd_d[bsq_pkg::FLAG_Z_BIT], flag_z);
          next_pc = cmd_d[19:0];
        end
        bsq_pkg::OP_CALL_HUB_STACK_A_IMM, bsq_pkg::OP_CALL_HUB_STACK_A_REG,
        bsq_pkg::OP_CALL_HUB_STACK_B_IMM, bsq_pkg::OP_CALL_HUB_STACK_B_REG:
        begin
          hub_go        = 1'b1; // RQ3
          hub_b         = (op == bsq_pkg::OP_CALL_HUB_STACK_B_IMM) || (op == bsq_pkg::OP_CALL_HUB_STACK_B_REG);
          next_hub_addr = hub_b ? hub_pointer_b[19:0] : hub_pointer_a[19:0];
          next_pc       = tgt;
          if ((op == bsq_pkg::OP_CALL_HUB_STACK_A_REG) || (op == bsq_pkg::OP_CALL_HUB_STACK_B_REG))
          begin
            next_c  = pick(cmd_write_carry, cmd_d[bsq_pkg::FLAG_C_BIT], flag_c);
            next_z  = pick(cmd_write_zero, cmd_d[bsq_pkg::FLAG_Z_BIT], flag_z);
            next_pc = cmd_d[19:0];
          end
        end
        bsq_pkg::OP_CALL_TO_REGISTER:
        begin
          wb_en   = 1'b1; // RQ4
          next_c  = pick(cmd_write_carry, cmd_s[bsq_pkg::FLAG_C_BIT], flag_c);
          next_z  = pick(cmd_write_zero, cmd_s[bsq_pkg::FLAG_Z_BIT], flag_z);
          next_pc = tgt;
        end
        bsq_pkg::OP_CALL_TO_REGISTER_IMM:
        begin
          wb_en      = !cmd_sel[1]; // RQ5
          wb_addr    = cmd_sel[0] ? bsq_pkg::REG_PARAM_B : bsq_pkg::REG_PARAM_A;
          ptr_load_a = (cmd_sel == 2'b10);
          ptr_load_b = (cmd_sel == 2'b11);
          next_pc    = tgt;
        end
        bsq_pkg::OP_CALL_WITH_PARAM_A, bsq_pkg::OP_CALL_WITH_PARAM_B:
        begin
          push    = 1'b1; // RQ6
          wb_en   = 1'b1;
          wb_addr = (op == bsq_pkg::OP_CALL_WITH_PARAM_B) ? bsq_pkg::REG_PARAM_B : bsq_pkg::REG_PARAM_A;
          wb_data = cmd_d;
          next_pc = tgt;
        end
        bsq_pkg::OP_INTERRUPT_RETURN, bsq_pkg::OP_INTERRUPT_RESUME:
        begin
          wb_en   = 1'b1; // RQ15
          wb_addr = (op == bsq_pkg::OP_INTERRUPT_RETURN) ? bsq_pkg::REG_TOP : bsq_pkg::INT_RES_DST[cmd_sel];
          next_c  = cmd_s[bsq_pkg::FLAG_C_BIT];
          next_z  = cmd_s[bsq_pkg::FLAG_Z_BIT];
          next_pc = cmd_s[19:0];
        end
        bsq_pkg::OP_DEC_BR_ZERO, bsq_pkg::OP_DECREMENT_BRANCH_NONZERO,
        bsq_pkg::OP_DEC_BR_ONES, bsq_pkg::OP_DEC_BR_NOT_ONES:
        begin
          wb_en   = 1'b1; // RQ7
          wb_data = dec_res;
          next_pc = taken ? tgt : next_seq; // RQ20
        end
        bsq_pkg::OP_INC_BR_ZERO, bsq_pkg::OP_INCREMENT_BRANCH_NONZERO:
        begin
          wb_en   = 1'b1; // RQ8
          wb_data = inc_res;
          next_pc = taken ? tgt : next_seq; // RQ20
        end
        bsq_pkg::OP_TEST_BR_ZERO, bsq_pkg::OP_TEST_BR_NONZERO, bsq_pkg::OP_TEST_BR_ONES,
        bsq_pkg::OP_TEST_BR_NOT_ONES, bsq_pkg::OP_TEST_BR_SIGN, bsq_pkg::OP_TEST_BR_NOT_SIGN,
        bsq_pkg::OP_TEST_BRANCH_OVERFLOW:
          next_pc = taken ? tgt : next_seq; // RQ9 RQ10 RQ20
        bsq_pkg::OP_JUMP_IMM:
          next_pc = tgt;
        bsq_pkg::OP_RELATIVE_JUMP:
          next_pc = hubex ? next_seq + {cmd_d[17:0], 2'b00} : next_seq + cmd_d[19:0]; // RQ12
        bsq_pkg::OP_EXECUTE_FAST_SKIP:
        begin
          next_pc      = {10'h000, cmd_d[9:0]}; // RQ13
          load_skip    = 1'b1;
          skip_fast_in = 1'b1;
          skip_val     = {10'h000, cmd_d[31:10]};
        end
        bsq_pkg::OP_REPEAT_BLOCK:
          load_rep = 1'b1; // RQ14
        bsq_pkg::OP_RETURN:
        begin
          pop     = 1'b1; // RQ16
          next_c  = pick(cmd_write_carry, stack_top[bsq_pkg::FLAG_C_BIT], flag_c);
          next_z  = pick(cmd_write_zero, stack_top[bsq_pkg::FLAG_Z_BIT], flag_z);
          next_pc = stack_top[19:0];
        end
        bsq_pkg::OP_RETURN_HUB_STACK_A, bsq_pkg::OP_RETURN_HUB_STACK_B:
        begin
          hub_go        = 1'b1; // RQ17
          hub_rd        = 1'b1;
          hub_b         = (op == bsq_pkg::OP_RETURN_HUB_STACK_B);
          next_hub_addr = hub_b ? hub_pointer_b[19:0] - 20'h00004 : hub_pointer_a[19:0] - 20'h00004;
          next_pc       = pc;
        end
        bsq_pkg::OP_SKIP:
          load_skip = 1'b1; // RQ18
        bsq_pkg::OP_FAST_SKIP:
        begin
          fault        = hubex; // RQ19
          load_skip    = !hubex;
          skip_fast_in = 1'b1;
        end
        bsq_pkg::OP_NOP:
          next_pc = rep_wrap ? rep_start : next_seq;
        default:
          fault = 1'b1;
      endcase
    end
  end

  // Program counter and flags
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pc     <= bsq_pkg::PC_RESET;
      flag_c <= 1'b0;
      flag_z <= 1'b0;
    end
    else if (state == bsq_pkg::ST_HUB_RD && hub_ack)
    begin
      pc     <= hub_rdata[19:0]; // RQ17
      flag_c <= pick(pend_wc, hub_rdata[bsq_pkg::FLAG_C_BIT], flag_c);
      flag_z <= pick(pend_wz, hub_rdata[bsq_pkg::FLAG_Z_BIT], flag_z);
    end
    else if (fast_leap)
      pc <= pc + bsq_pkg::STEP_COG; // RQ19
    else if (op_go || step_go)
    begin
      pc     <= next_pc;
      flag_c <= next_c;
      flag_z <= next_z;
    end
  end

  // Skip mask, consumed one bit per instruction
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      skip_mask <= bsq_pkg::SKIP_RESET;
      skip_fast <= 1'b0;
    end
    else if (load_skip)
    begin
      skip_mask <= skip_val; // RQ18
      skip_fast <= skip_fast_in;
    end
    else if (fast_leap || op_go || step_go)
      skip_mask <= {1'b0, skip_mask[31:1]};
  end

  // Repeat block tracking
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rep_active  <= 1'b0;
      rep_forever <= 1'b0;
      rep_left    <= '0;
      rep_start   <= bsq_pkg::PC_RESET;
      rep_end     <= bsq_pkg::PC_RESET;
    end
    else if (load_rep)
    begin
      rep_active  <= (cmd_d[8:0] != 9'h000); // RQ14
      rep_forever <= (cmd_s == '0);
      rep_left    <= cmd_s;
      rep_start   <= next_seq;
      rep_end     <= next_seq + (hubex ? {9'h000, cmd_d[8:0], 2'b00} : {11'h000, cmd_d[8:0]});
    end
    else if ((step_go || (op_go && op == bsq_pkg::OP_NOP)) && rep_end_hit)
    begin
      rep_active <= rep_wrap;
      rep_left   <= rep_left - 32'h00000001;
    end
  end

  // Hub stack pointers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hub_pointer_a <= bsq_pkg::PTR_RESET;
      hub_pointer_b <= bsq_pkg::PTR_RESET;
    end
    else if (ptr_load_a)
      hub_pointer_a <= ret_word; // RQ5
    else if (ptr_load_b)
      hub_pointer_b <= ret_word;
    else if (state == bsq_pkg::ST_HUB_WR && hub_ack)
    begin
      if (pend_b)
        hub_pointer_b <= hub_pointer_b + bsq_pkg::HUB_LONG; // RQ3
      else
        hub_pointer_a <= hub_pointer_a + bsq_pkg::HUB_LONG;
    end
    else if (hub_go && hub_rd)
    begin
      if (hub_b)
        hub_pointer_b <= hub_pointer_b - bsq_pkg::HUB_LONG;
      else
        hub_pointer_a <= hub_pointer_a - bsq_pkg::HUB_LONG;
    end
  end

  // Hub access sequencing
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state     <= bsq_pkg::ST_RUN;
      hub_req   <= 1'b0;
      hub_we    <= 1'b0;
      hub_addr  <= '0;
      hub_wdata <= '0;
      pend_wc   <= 1'b0;
      pend_wz   <= 1'b0;
      pend_b    <= 1'b0;
    end
    else if (hub_go)
    begin
      state     <= hub_rd ? bsq_pkg::ST_HUB_RD : bsq_pkg::ST_HUB_WR;
      hub_req   <= 1'b1;
      hub_we    <= !hub_rd;
      hub_addr  <= next_hub_addr;
      hub_wdata <= ret_word; // RQ3
      pend_wc   <= cmd_write_carry;
      pend_wz   <= cmd_write_zero;
      pend_b    <= hub_b;
    end
    else if (state != bsq_pkg::ST_RUN && hub_ack)
    begin
      state   <= bsq_pkg::ST_RUN;
      hub_req <= 1'b0;
      hub_we  <= 1'b0;
    end
  end

  // Register writeback and fault pulse
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_we    <= 1'b0;
      reg_waddr <= '0;
      reg_wdata <= '0;
      illegal   <= 1'b0;
    end
    else
    begin
      reg_we    <= wb_en; // RQ4 RQ6 RQ7 RQ8
      reg_waddr <= wb_addr;
      reg_wdata <= wb_data;
      illegal   <= fault;
    end
  end

  default clocking dcb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic top_c;
  assign top_c = stack_top[bsq_pkg::FLAG_C_BIT];

  sequence hub_call_issue;
    op_go && (op == bsq_pkg::OP_CALL_HUB_STACK_A_IMM);
  endsequence

  sequence hub_write_held;
    (hub_req && hub_we && !cmd_ready) [*1];
  endsequence

  chk_call_push: assert property ( // RQ1
    op_go && op == bsq_pkg::OP_CALL_IMM |=> stack_top == $past(ret_word) && pc == $past(tgt))
    else $error("Immediate call did not push and jump");

  chk_reg_call_flags: assert property ( // RQ2
    op_go && op == bsq_pkg::OP_CALL_REG && cmd_write_carry |=> flag_c == $past(cmd_d[31]))
    else $error("Register call did not load carry");

  chk_hub_call_write: assert property ( // RQ3
    hub_call_issue |=> hub_write_held ##0 (hub_addr == $past(hub_pointer_a[19:0])))
    else $error("Hub call did not write at pointer A");

  chk_hub_ptr_incr: assert property ( // RQ3
    state == bsq_pkg::ST_HUB_WR && hub_ack && !pend_b |=> hub_pointer_a == $past(hub_pointer_a) + 32'h4)
    else $error("Pointer A not incremented after hub call");

  chk_dec_branch_zero: assert property ( // RQ7
    op_go && op == bsq_pkg::OP_DEC_BR_ZERO && cmd_d == 32'h1 |=> pc == $past(tgt) && reg_we && reg_wdata == '0)
    else $error("Decrement branch on zero misbehaved");

  chk_test_no_write: assert property ( // RQ9
    op_go && op == bsq_pkg::OP_TEST_BR_ZERO |=> !reg_we)
    else $error("Test branch wrote the register");

  chk_overflow_jump: assert property ( // RQ10
    op_go && op == bsq_pkg::OP_TEST_BRANCH_OVERFLOW && cmd_d[31] != flag_c |=> pc == $past(tgt))
    else $error("Overflow test branch not taken");

  chk_rep_zero_len: assert property ( // RQ14
    op_go && op == bsq_pkg::OP_REPEAT_BLOCK && cmd_d[8:0] == 9'h000 |=> !rep_active)
    else $error("Zero-length repeat became active");

  chk_ret_restore: assert property ( // RQ16
    op_go && op == bsq_pkg::OP_RETURN && cmd_write_carry |=> flag_c == $past(top_c))
    else $error("Stack return did not restore carry");

  chk_skip_cancel: assert property ( // RQ18
    op_go && op == bsq_pkg::OP_SKIP && cmd_d[0] |=> cancel ##1 1'b1)
    else $error("Skip did not cancel first instruction");

  chk_fast_skip_hub: assert property ( // RQ19
    op_go && op == bsq_pkg::OP_FAST_SKIP && hubex |=> illegal && !skip_fast)
    else $error("Fast skip in hub not flagged");

  chk_false_sequential: assert property ( // RQ20
    op_go && op == bsq_pkg::OP_DECREMENT_BRANCH_NONZERO && cmd_d == 32'h1
    |=> pc == $past(next_seq) && flag_c == $past(flag_c) && reg_we)
    else $error("False branch did not continue in sequence");
endmodule // bsq_branch_sequencer

// ### test/bsq_hub_mem.sv
/*
  Behavioural shared hub memory holding stacked return words.
  Assumes requests hold until acknowledged; answers after four cycles.
*/
`timescale 1ns/1ps
module bsq_hub_mem (
  input  wire logic        clk,
  input  wire logic        hub_req,
  input  wire logic        hub_we,
  input  wire logic [19:0] hub_addr,
  input  wire logic [31:0] hub_wdata,
  output logic      [31:0] hub_rdata,
  output logic             hub_ack
);
  logic [31:0] mem [256];
  logic [1:0]  wait_cnt = 2'h0;

  initial hub_ack = 1'b0;
  initial hub_rdata = 32'h0;
  // Read data toggles every cycle except the cycle that acknowledges a read
  always @(posedge clk)
  begin
    hub_ack <= 1'b0;
    hub_rdata <= ~hub_rdata;
    if (hub_req && !hub_ack)
    begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt == 2'h3)
      begin
        hub_ack <= 1'b1;
        if (hub_we)
          mem[hub_addr[9:2]] <= hub_wdata;
        else
          hub_rdata <= mem[hub_addr[9:2]];
      end
    end
  end
endmodule // bsq_hub_mem

// ### test/bsq_branch_sequencer_test.sv
/*
  Self-checking bench for the branch sequencer.
  Assumes the hub memory model answers every hub request.
*/
`timescale 1ns/1ps
module bsq_branch_sequencer_test;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_ready, cancel, illegal, flag_c, flag_z, reg_we, hub_req, hub_we, hub_ack;
  logic [5:0]  cmd_op = 6'h0;
  logic [31:0] cmd_d = 32'h0;
  logic [31:0] cmd_s = 32'h0;
  logic [8:0]  cmd_dst = 9'h010;
  logic        cmd_rel = 1'b0;
  logic        cmd_abs = 1'b0;
  logic [1:0]  cmd_sel = 2'h0;
  logic        cmd_write_carry = 1'b0;
  logic        cmd_write_zero = 1'b0;
  logic        step_valid = 1'b0;
  logic [19:0] pc, hub_addr;
  logic [8:0]  reg_waddr;
  logic [31:0] hub_pointer_a, hub_pointer_b, reg_wdata, hub_wdata, hub_rdata, wd;
  logic        we, ill;
  int          n_mismatch = 0;
  int          compares = 0;

  bsq_branch_sequencer u_bsq_branch_sequencer (.clk, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_d,
    .cmd_s, .cmd_dst, .cmd_rel, .cmd_abs, .cmd_sel, .cmd_write_carry, .cmd_write_zero,
    .step_valid, .cancel, .illegal, .pc, .flag_c, .flag_z, .hub_pointer_a, .hub_pointer_b, .reg_we,
    .reg_waddr, .reg_wdata, .hub_req, .hub_we, .hub_addr, .hub_wdata, .hub_rdata, .hub_ack);
  bsq_hub_mem u_bsq_hub_mem (.clk, .hub_req, .hub_we, .hub_addr, .hub_wdata, .hub_rdata, .hub_ack);

  initial forever #12.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One instruction; waits until the block is ready again
  task automatic issue(input logic [5:0] op, input logic [31:0] d, input logic [31:0] s, input logic write_carry_zero);
    int n;
    n = 0;
    @(negedge clk);
    while ((cmd_ready !== 1'b1 || cancel !== 1'b0) && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    cmd_op = op;
    cmd_d = d;
    cmd_s = s;
    cmd_write_carry = write_carry_zero;
    cmd_write_zero = write_carry_zero;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    we = reg_we;
    wd = reg_wdata;
    ill = illegal;
    while (cmd_ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 100)
      n_mismatch++;
  endtask

  task automatic t_call_ret;
    issue(bsq_pkg::OP_CALL_IMM, 32'h0, 32'h100, 1'b0);
    check({12'h0, pc}, 32'h100);
    step_valid = 1'b1;
    @(negedge clk);
    step_valid = 1'b0;
    check({12'h0, pc}, 32'h101);
    issue(bsq_pkg::OP_RETURN, 32'h0, 32'h0, 1'b0);
    check({12'h0, pc}, 32'h1);
  endtask

  task automatic t_jump;
    issue(bsq_pkg::OP_JUMP_REG, 32'hC0000050, 32'h0, 1'b1);
    check({10'h0, flag_c, flag_z, pc}, 32'h300050);
    cmd_rel = 1'b1;
    issue(bsq_pkg::OP_JUMP_IMM, 32'h0, 32'h10, 1'b0);
    cmd_rel = 1'b0;
    check({12'h0, pc}, 32'h61);
  endtask

  task automatic t_branch;
    issue(bsq_pkg::OP_DEC_BR_ZERO, 32'h1, 32'h200, 1'b0);
    check({we, reg_waddr, wd[21:0]}, {1'b1, 9'h010, 22'h0});
    check({12'h0, pc}, 32'h200);
    issue(bsq_pkg::OP_TEST_BR_SIGN, 32'h0, 32'h10, 1'b0);
    check({10'h0, flag_c, flag_z, pc}, 32'h300201);
  endtask

  task automatic t_hub;
    issue(bsq_pkg::OP_CALL_HUB_STACK_A_IMM, 32'h0, 32'h300, 1'b0);
    check(hub_pointer_a, 32'h4);
    issue(bsq_pkg::OP_JUMP_REG, 32'h300, 32'h0, 1'b1);
    issue(bsq_pkg::OP_RETURN_HUB_STACK_A, 32'h0, 32'h0, 1'b1);
    check({10'h0, flag_c, flag_z, pc}, 32'h300202);
    check(hub_pointer_a, 32'h0);
  endtask

  task automatic t_misc;
    cmd_rel = 1'b1;
    cmd_abs = 1'b1;
    cmd_sel = 2'h1;
    issue(bsq_pkg::OP_CALL_TO_REGISTER_IMM, 32'h0, 32'h40, 1'b0);
    check({we, reg_waddr, wd[21:0]}, {1'b1, 9'h1F7, 22'h000203});
    check({12'h0, pc}, 32'h40);
    cmd_rel = 1'b0;
    cmd_abs = 1'b0;
    issue(bsq_pkg::OP_SKIP, 32'h1, 32'h0, 1'b0);
    check({31'h0, cancel}, 32'h1);
    step_valid = 1'b1;
    @(negedge clk);
    step_valid = 1'b0;
    check({31'h0, cancel}, 32'h0);
    check({12'h0, pc}, 32'h42);
    issue(bsq_pkg::OP_TEST_BRANCH_OVERFLOW, 32'h0, 32'h80, 1'b0);
    check({12'h0, pc}, 32'h80);
    issue(bsq_pkg::OP_CALL_IMM, 32'h0, 32'h90, 1'b0);
    issue(bsq_pkg::OP_JUMP_REG, 32'h0, 32'h0, 1'b1);
    issue(bsq_pkg::OP_RETURN, 32'h0, 32'h0, 1'b1);
    check({10'h0, flag_c, flag_z, pc}, 32'h300081);
    issue(bsq_pkg::OP_DECREMENT_BRANCH_NONZERO, 32'h1, 32'h10, 1'b0);
    check({we, wd[30:0]}, 32'h80000000);
    check({12'h0, pc}, 32'h82);
    issue(bsq_pkg::OP_JUMP_IMM, 32'h0, 32'h400, 1'b0);
    issue(bsq_pkg::OP_FAST_SKIP, 32'h1, 32'h0, 1'b0);
    check({31'h0, ill}, 32'h1);
    issue(bsq_pkg::OP_RELATIVE_JUMP, 32'h2, 32'h0, 1'b0);
    check({12'h0, pc}, 32'h410);
  endtask

  task automatic summarize;
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    t_call_ret();
    t_jump();
    t_branch();
    t_hub();
    t_misc();
    summarize();
  end

  initial
  begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule // bsq_branch_sequencer_test
